/* File: ccf_flag_unit.sv */
// Condition code flag unit: flags, priority bits, stack and branch test.
// Assumes the core presents one operation per cycle with opValid high.
//
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module ccf_flag_unit
   import ccf_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic opValid,
   input wire logic [4:0] opCode,
   input wire logic [7:0] operandA,
   input wire logic [7:0] operandB,
   input wire logic [1:0] irqPriority,
   input wire logic [7:0] popData,
   input wire logic [1:0] branchSel,
   input wire logic branchIfSet,
   output logic [7:0] flagsOut,
   output logic [7:0] resultOut,
   output logic resultValid,
   output logic [7:0] pushData,
   output logic pushValid,
   output logic branchTaken,
   output logic branchValid,
   output logic haltedOut,
   output logic waitingOut
);

   typedef struct packed {
      logic [7:0] flags;
      logic [7:0] result;
      logic resultValid;
      logic [7:0] pushData;
      logic pushValid;
      logic branchTaken;
      logic branchValid;
      logic halted;
      logic waiting;
   } ccf_core_s;

   ccf_core_s st_reg;
   ccf_core_s st_next;
   logic [8:0] sumWide;
   logic [4:0] nibble;
   logic [7:0] res;
   logic carryIn;
   logic resultOp;
   ccf_op_e op;

   ccf_reg_if regIf ();
   ccf_br_if brIf ();

   ////////////////////////////////////////////////////////////////////////
   // Register bus slave
   ccf_ahb_slave u_ahb (
      .clk(clk),
      .arst_n(arst_n),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .regs(regIf)
   );

   ////////////////////////////////////////////////////////////////////////
   // Branch condition test
   ccf_branch_eval u_branch (
      .br(brIf)
   );

   assign brIf.flags = st_reg.flags;
   assign brIf.sel = branchSel;
   assign brIf.ifSet = branchIfSet;
   assign op = ccf_op_e'(opCode);

   ////////////////////////////////////////////////////////////////////////
   // ALU flag computation
   always_comb
   begin
      sumWide = 9'h000;
      nibble = 5'h00;
      res = 8'h00;
      resultOp = 1'b0;
      carryIn = 1'b0;
      if (op == OP_ADC || op == OP_SBC)
      begin
         carryIn = st_reg.flags[BIT_C];
      end
      unique case (op)
         OP_ADD, OP_ADC:
         begin
            sumWide = {1'b0, operandA} + {1'b0, operandB} + {8'h00, carryIn};
            nibble = {1'b0, operandA[3:0]} + {1'b0, operandB[3:0]} +
                     {4'h0, carryIn};
            res = sumWide[7:0];
            resultOp = 1'b1;
         end
         OP_SUB, OP_SBC:
         begin
            sumWide = {1'b0, operandA} - {1'b0, operandB} - {8'h00, carryIn};
            res = sumWide[7:0];
            resultOp = 1'b1;
         end
         OP_AND:
         begin
            res = operandA & operandB;
            resultOp = 1'b1;
         end
         OP_OR:
         begin
            res = operandA | operandB;
            resultOp = 1'b1;
         end
         OP_XOR:
         begin
            res = operandA ^ operandB;
            resultOp = 1'b1;
         end
         OP_LOAD:
         begin
            res = operandB;
            resultOp = 1'b1;
         end
         OP_SHL:
         begin
            res = {operandA[6:0], 1'b0};
            resultOp = 1'b1;
         end
         OP_SHR:
         begin
            res = {1'b0, operandA[7:1]};
            resultOp = 1'b1;
         end
         OP_RLC:
         begin
            res = {operandA[6:0], st_reg.flags[BIT_C]};
            resultOp = 1'b1;
         end
         OP_RRC:
         begin
            res = {st_reg.flags[BIT_C], operandA[7:1]};
            resultOp = 1'b1;
         end
         default:
         begin
            res = 8'h00;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state of flags, stack and status
   always_comb
   begin
      st_next = st_reg;
      st_next.resultValid = 1'b0;
      st_next.pushValid = 1'b0;
      st_next.branchValid = 1'b0;
      if (opValid)
      begin
         if (resultOp)
         begin
            st_next.result = res;
            st_next.resultValid = 1'b1;
            st_next.flags[BIT_N] = res[7];
            st_next.flags[BIT_Z] = (res == 8'h00);
         end
         unique case (op)
            OP_ADD, OP_ADC:
            begin
               st_next.flags[BIT_H] = nibble[4];
               st_next.flags[BIT_C] = sumWide[8];
            end
            OP_SUB, OP_SBC:
            begin
               st_next.flags[BIT_C] = sumWide[8];
            end
            OP_SHL, OP_RLC:
            begin
               st_next.flags[BIT_C] = operandA[7];
            end
            OP_SHR, OP_RRC:
            begin
               st_next.flags[BIT_C] = operandA[0];
            end
            OP_BTJ:
            begin
               st_next.flags[BIT_C] = operandA[operandB[2:0]];
            end
            OP_SCF:
            begin
               st_next.flags[BIT_C] = 1'b1;
            end
            OP_RCF:
            begin
               st_next.flags[BIT_C] = 1'b0;
            end
            OP_RIM:
            begin
               st_next.flags = set_prio(st_reg.flags,
                                        PRIO_LEVEL0);
            end
            OP_SIM:
            begin
               st_next.flags = set_prio(st_reg.flags,
                                        PRIO_LEVEL3);
            end
            OP_HALT:
            begin
               st_next.flags = set_prio(st_reg.flags,
                                        PRIO_LEVEL0);
               st_next.halted = 1'b1;
            end
            OP_WFI:
            begin
               st_next.flags = set_prio(st_reg.flags,
                                        PRIO_LEVEL0);
               st_next.waiting = 1'b1;
            end
            OP_PUSH:
            begin
               st_next.pushData = st_reg.flags;
               st_next.pushValid = 1'b1;
            end
            OP_POP:
            begin
               st_next.flags = load_flags(popData);
            end
            OP_IRQ_RETURN_INSTR:
            begin
               st_next.flags = load_flags(popData);
            end
            OP_IRQ:
            begin
               st_next.pushData = st_reg.flags;
               st_next.pushValid = 1'b1;
               st_next.flags = set_prio(st_reg.flags,
                                        irqPriority);
               st_next.halted = 1'b0;
               st_next.waiting = 1'b0;
            end
            OP_BRANCH:
            begin
               st_next.branchTaken = brIf.taken;
               st_next.branchValid = 1'b1;
            end
            default:
            begin
               st_next.branchValid = 1'b0;
            end
         endcase
      end
      else if (regIf.wrFlags)
      begin
         st_next.flags = load_flags(regIf.wrData);
      end
      st_next.flags = load_flags(st_next.flags);
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_reg <= '{flags: FLAGS_RESET, result: 8'h00, resultValid: 1'b0,
                     pushData: 8'h00, pushValid: 1'b0, branchTaken: 1'b0,
                     branchValid: 1'b0, halted: 1'b0,
                     waiting: 1'b0};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register views for the bus
   always_comb
   begin
      regIf.flagsNext = st_next.flags;
      regIf.statusNext = 32'h0000_0000;
      regIf.statusNext[7:0] = st_next.result;
      regIf.statusNext[STS_BRANCH] = st_next.branchTaken;
      regIf.statusNext[STS_HALTED] = st_next.halted;
      regIf.statusNext[STS_WAITING] = st_next.waiting;
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign flagsOut = st_reg.flags;
   assign resultOut = st_reg.result;
   assign resultValid = st_reg.resultValid;
   assign pushData = st_reg.pushData;
   assign pushValid = st_reg.pushValid;
   assign branchTaken = st_reg.branchTaken;
   assign branchValid = st_reg.branchValid;
   assign haltedOut = st_reg.halted;
   assign waitingOut = st_reg.waiting;

endmodule : ccf_flag_unit
`default_nettype wire

/* File: ccf_pkg.sv */
// Constants, types and helpers of the condition code flag unit.
// Assumes one core clock domain and AHB-Lite register access.
//
// Functional notes
// - Add and add-with-carry set bit 4 on carry out of bit 3, else clear.
// - ALU and data operations copy result bit 7 into bit 2.
// - ALU and data operations set bit 1 on zero result, else clear.
// - Bit 0 is carry/borrow; hardware and software may change it.
// - Set/reset-carry force bit 0; bit test, shift, rotate update it.
// - Priority bits 5,3: 10=L0, 01=L1, 00=L2, 11=L3 with interrupts off.
// - Interrupt entry loads both priority bits from its priority config.
// - Enable, disable, return, halt, wait and pop alter priority bits; push does not.
// - Eight-bit register, read and written whole, pushed and popped.
// - Relative branches test one flag, in set and clear pairs.
// - Halt forces the priority bits to binary 10, enabling interrupts.
// - Interrupt entry pushes the register; return pops it back.
`default_nettype none
package ccf_pkg;

   localparam int unsigned BIT_C = 0;
   localparam int unsigned BIT_Z = 1;
   localparam int unsigned BIT_N = 2;
   localparam int unsigned BIT_I0 = 3;
   localparam int unsigned BIT_H = 4;
   localparam int unsigned BIT_I1 = 5;
   localparam logic [7:0] FLAGS_UNUSED_ONES = 8'hc0;
   localparam logic [7:0] FLAGS_RESET = 8'he8;

   localparam logic [1:0] PRIO_LEVEL0 = 2'b10;
   localparam logic [1:0] PRIO_LEVEL1 = 2'b01;
   localparam logic [1:0] PRIO_LEVEL2 = 2'b00;
   localparam logic [1:0] PRIO_LEVEL3 = 2'b11;

   localparam logic [31:0] OFS_FLAGS = 32'h0000_0000;
   localparam logic [31:0] OFS_STATUS = 32'h0000_0004;
   localparam int unsigned STS_BRANCH = 8;
   localparam int unsigned STS_HALTED = 9;
   localparam int unsigned STS_WAITING = 10;

   typedef enum logic [4:0] {
      OP_NONE = 5'h00, OP_ADD = 5'h01, OP_ADC = 5'h02, OP_SUB = 5'h03,
      OP_SBC = 5'h04, OP_AND = 5'h05, OP_OR = 5'h06, OP_XOR = 5'h07,
      OP_LOAD = 5'h08, OP_SHL = 5'h09, OP_SHR = 5'h0a, OP_RLC = 5'h0b,
      OP_RRC = 5'h0c, OP_BTJ = 5'h0d, OP_SCF = 5'h0e, OP_RCF = 5'h0f,
      OP_RIM = 5'h10, OP_SIM = 5'h11, OP_HALT = 5'h12, OP_WFI = 5'h13,
      OP_PUSH = 5'h14, OP_POP = 5'h15, OP_IRQ_RETURN_INSTR = 5'h16, OP_IRQ = 5'h17,
      OP_BRANCH = 5'h18
   } ccf_op_e;

   typedef enum logic [1:0] {
      SEL_H = 2'b00,
      SEL_N = 2'b01,
      SEL_Z = 2'b10,
      SEL_C = 2'b11
   } ccf_sel_e;

   // Places a priority code {high, low} into bits 5 and 3
   function automatic logic [7:0] set_prio(input logic [7:0] flags,
                                           input logic [1:0] code);
      logic [7:0] v;
      v = flags;
      v[BIT_I1] = code[1];
      v[BIT_I0] = code[0];
      return v;
   endfunction : set_prio

   // Whole-byte load keeps the unused bits at one
   function automatic logic [7:0] load_flags(input logic [7:0] value);
      return value | FLAGS_UNUSED_ONES;
   endfunction : load_flags

endpackage : ccf_pkg
`default_nettype wire

/* File: ccf_ifs.sv */
// Interfaces between the flag unit core, its bus slave and branch test.
// Assumes all parties run on the same core clock.
`timescale 1ns/1ps
`default_nettype none

interface ccf_reg_if;
   logic wrFlags;
   logic [7:0] wrData;
   logic [7:0] flagsNext;
   logic [31:0] statusNext;
   modport slave (output wrFlags, output wrData,
                  input flagsNext, input statusNext);
   modport core (input wrFlags, input wrData,
                 output flagsNext, output statusNext);
endinterface : ccf_reg_if

interface ccf_br_if;
   logic [7:0] flags;
   logic [1:0] sel;
   logic ifSet;
   logic taken;
   modport eval (input flags, input sel, input ifSet, output taken);
   modport user (output flags, output sel, output ifSet, input taken);
endinterface : ccf_br_if

`default_nettype wire

/* File: ccf_branch_eval.sv */
// Branch condition test of the flag unit.
// Assumes flags and selector are stable within the cycle.
`timescale 1ns/1ps
`default_nettype none

module ccf_branch_eval
   import ccf_pkg::*;
(
   ccf_br_if.eval br
);

   logic flagBit;

   ////////////////////////////////////////////////////////////////////////
   // Flag select and sense compare
   always_comb
   begin
      unique case (ccf_sel_e'(br.sel))
         SEL_H: flagBit = br.flags[BIT_H];
         SEL_N: flagBit = br.flags[BIT_N];
         SEL_Z: flagBit = br.flags[BIT_Z];
         SEL_C: flagBit = br.flags[BIT_C];
      endcase
   end

   assign br.taken = (flagBit == br.ifSet);

endmodule : ccf_branch_eval
`default_nettype wire

/* File: ccf_ahb_slave.sv */
// AHB-Lite slave for the flag unit registers, zero wait states.
// Assumes single word transfers; response is always OKAY.
`timescale 1ns/1ps
`default_nettype none

module ccf_ahb_slave
   import ccf_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   ccf_reg_if.slave regs
);

   typedef struct packed {
      logic wrPending;
      logic wrFlagsSel;
      logic [31:0] rdata;
      logic readyOut;
      logic respErr;
   } ccf_ahb_s;

   ccf_ahb_s r_reg;
   ccf_ahb_s r_next;
   logic accept;
   logic unusedSize;

   function automatic logic is_flags_addr(input logic [31:0] addr);
      return addr == OFS_FLAGS;
   endfunction : is_flags_addr

   ////////////////////////////////////////////////////////////////////////
   // Address phase capture, read data from next register values
   always_comb
   begin
      r_next = r_reg;
      accept = hsel & htrans[1] & hready;
      unusedSize = ^hsize;
      r_next.wrPending = 1'b0;
      r_next.wrFlagsSel = 1'b0;
      r_next.readyOut = 1'b1;
      r_next.respErr = 1'b0;
      if (accept)
      begin
         r_next.wrPending = hwrite;
         r_next.wrFlagsSel = is_flags_addr(haddr);
         r_next.rdata = 32'h0000_0000;
         if (!hwrite && is_flags_addr(haddr))
         begin
            r_next.rdata = {24'h00_0000, regs.flagsNext};
         end
         else if (!hwrite && haddr == OFS_STATUS)
         begin
            r_next.rdata = regs.statusNext;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         r_reg <= '{wrPending: 1'b0, wrFlagsSel: 1'b0, rdata: 32'h0000_0000,
                    readyOut: 1'b1, respErr: 1'b0};
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data phase write strobe
   assign regs.wrFlags = r_reg.wrPending & r_reg.wrFlagsSel;
   assign regs.wrData = hwdata[7:0];
   assign hrdata = r_reg.rdata;
   assign hreadyout = r_reg.readyOut;
   assign hresp = r_reg.respErr;

endmodule : ccf_ahb_slave
`default_nettype wire

/* File: ccf_flag_monitor.sv */
// Checker of the flag unit: flag, priority, stack and branch relations.
// Assumes it is bound to ccf_flag_unit and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module ccf_flag_monitor
   import ccf_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic opValid,
   input wire logic [4:0] opCode,
   input wire logic [7:0] operandA,
   input wire logic [7:0] operandB,
   input wire logic [1:0] irqPriority,
   input wire logic [7:0] popData,
   input wire logic [1:0] branchSel,
   input wire logic branchIfSet,
   input wire logic [7:0] flagsOut,
   input wire logic [7:0] resultOut,
   input wire logic [7:0] pushData,
   input wire logic pushValid,
   input wire logic branchTaken,
   input wire logic branchValid,
   input wire logic haltedOut
);

   logic halfCarry;
   logic selFlag;

   assign halfCarry = ({1'b0, operandA[3:0]} + {1'b0, operandB[3:0]}) > 5'h0f;
   assign selFlag = (branchSel == 2'd0) ? flagsOut[4] :
                    (branchSel == 2'd1) ? flagsOut[2] :
                    (branchSel == 2'd2) ? flagsOut[1] : flagsOut[0];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   ////////////////////////////////////////////////////////////////////////
   // Operation sequences
   sequence s_op(logic [4:0] code);
      opValid && opCode == code;
   endsequence
   sequence s_restore;
      opValid && (opCode == 5'h15 || opCode == 5'h16);
   endsequence

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   a_unused_ones: assert property (
      flagsOut[7:6] == 2'b11 && hreadyout && !hresp)
      else $error("unused flag bits or bus response wrong");
   a_half_carry: assert property (s_op(5'h01) |=>
      flagsOut[4] == $past(halfCarry))
      else $error("half carry wrong after add");
   a_sign_zero: assert property (
      opValid && opCode inside {[5'h01:5'h0c]} |=>
      flagsOut[2] == resultOut[7] && flagsOut[1] == (resultOut == 8'h00))
      else $error("negative or zero flag wrong");
   a_carry_force: assert property (
      opValid && opCode[4:1] == 4'h7 |=> flagsOut[0] == !$past(opCode[0]))
      else $error("set or reset carry wrong");
   a_disable_level: assert property (s_op(5'h11) |=>
      {flagsOut[5], flagsOut[3]} == PRIO_LEVEL3)
      else $error("disable did not give level 3");
   a_halt_enable: assert property (s_op(5'h12) |=>
      {flagsOut[5], flagsOut[3]} == PRIO_LEVEL0 && haltedOut)
      else $error("halt did not enable interrupts");
   a_irq_entry: assert property (s_op(5'h17) |=>
      pushValid && pushData == $past(flagsOut) &&
      {flagsOut[5], flagsOut[3]} == $past(irqPriority))
      else $error("interrupt entry push or priority wrong");
   a_pop_restore: assert property (s_restore |=>
      flagsOut == ($past(popData) | 8'hc0))
      else $error("pop did not restore flags");
   a_branch_test: assert property (s_op(5'h18) |=> branchValid &&
      branchTaken == ($past(selFlag) == $past(branchIfSet)))
      else $error("branch decision wrong");

endmodule : ccf_flag_monitor

bind ccf_flag_unit ccf_flag_monitor u_mon (.clk(clk), .arst_n(arst_n),
   .hreadyout(hreadyout), .hresp(hresp), .opValid(opValid), .opCode(opCode),
   .operandA(operandA), .operandB(operandB), .irqPriority(irqPriority),
   .popData(popData), .branchSel(branchSel), .branchIfSet(branchIfSet),
   .flagsOut(flagsOut), .resultOut(resultOut), .pushData(pushData),
   .pushValid(pushValid), .branchTaken(branchTaken),
   .branchValid(branchValid), .haltedOut(haltedOut));
`default_nettype wire

/* File: ccf_testbench.sv */
// Self-checking bench of the flag unit: bus access and core operations.
// Assumes the checker is bound to ccf_flag_unit; one 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module testbench
   import ccf_pkg::*;
();

   localparam logic [7:0] AV [5] = '{8'h08, 8'h80, 8'hff, 8'h70, 8'h00};
   localparam logic [7:0] BV [5] = '{8'h08, 8'h80, 8'h01, 8'h10, 8'h00};
   localparam int POS [4] = '{4, 2, 1, 0};
   localparam logic [4:0] SOP [8] = '{5'h09, 5'h04, 5'h0b, 5'h0c, 5'h0a,
      5'h06, 5'h07, 5'h08};
   localparam logic [7:0] SA [8] = '{8'h81, 8'h10, 8'h80, 8'h02, 8'h01,
      8'h40, 8'hff, 8'h00};
   localparam logic [7:0] SB [8] = '{8'h00, 8'h0f, 8'h00, 8'h00, 8'h00,
      8'h80, 8'hff, 8'h7f};
   localparam logic [10:0] SX [8] = '{11'h102, 11'h200, 11'h300, 11'h481,
      11'h300, 11'h5c0, 11'h300, 11'h17f};
   localparam logic [7:0] POP_FLAGS = 8'hfa;

   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0;
   wire logic hready;
   logic [31:0] hrdata;
   logic hresp;
   logic opValid = 1'b0;
   logic [4:0] opCode = 5'h00;
   logic [7:0] operandA = 8'h00;
   logic [7:0] operandB = 8'h00;
   logic [1:0] irqPriority = 2'b00;
   logic [7:0] popData = 8'h00;
   logic [1:0] branchSel = 2'b00;
   logic branchIfSet = 1'b0;
   logic [7:0] flagsOut, resultOut, pushData;
   logic resultValid, pushValid, branchTaken, branchValid;
   logic haltedOut, waitingOut;
   int n_fail = 0;
   int compares = 0;
   int cycles = 0;

   ccf_flag_unit dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
      .opValid(opValid), .opCode(opCode), .operandA(operandA),
      .operandB(operandB), .irqPriority(irqPriority), .popData(popData),
      .branchSel(branchSel), .branchIfSet(branchIfSet), .flagsOut(flagsOut),
      .resultOut(resultOut), .resultValid(resultValid), .pushData(pushData),
      .pushValid(pushValid), .branchTaken(branchTaken),
      .branchValid(branchValid), .haltedOut(haltedOut),
      .waitingOut(waitingOut));

   always #20 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   // Tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   // One single AHB-Lite transfer; read data taken at the data-phase end
   task automatic bus(input logic wr, input logic [31:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rdata);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= addr;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wdata;
      do @(posedge clk); while (hready !== 1'b1);
      rdata = hrdata;
   endtask : bus

   // One core operation; branch select and polarity ride on a[1:0], b[0]
   task automatic op(input logic [4:0] code, input logic [7:0] a,
                     input logic [7:0] b, input logic [7:0] d);
      @(posedge clk);
      opValid <= 1'b1;
      opCode <= code;
      operandA <= a;
      operandB <= b;
      popData <= d;
      irqPriority <= d[1:0];
      branchSel <= a[1:0];
      branchIfSet <= b[0];
      @(posedge clk);
      opValid <= 1'b0;
      #1;
   endtask : op

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_fail++;
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      logic [31:0] rd;
      logic [8:0] sum;
      logic [4:0] hs;
      logic [2:0] nzc;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      check(flagsOut, 8'he8);
      bus(1'b0, 32'h0, 32'h0, rd);
      check(rd, 32'he8);
      bus(1'b1, 32'h0, 32'h0, rd);
      bus(1'b0, 32'h0, 32'h0, rd);
      check(rd, 32'hc0);
      bus(1'b1, 32'h0, 32'h3f, rd);
      bus(1'b1, 32'h10, 32'h00, rd);
      bus(1'b0, 32'h10, 32'h0, rd);
      check(rd, 32'h0);
      check(flagsOut, 8'hff);
      for (int i = 0; i < 5; i++)
      begin
         sum = {1'b0, AV[i]} + {1'b0, BV[i]};
         hs = {1'b0, AV[i][3:0]} + {1'b0, BV[i][3:0]};
         nzc = {sum[7], sum[7:0] == 8'h00, sum[8]};
         op(5'h01, AV[i], BV[i], 8'h00);
         check({resultValid, resultOut}, {1'b1, sum[7:0]});
         check(flagsOut[4], hs[4]);
         check(flagsOut[2:0], nzc);
      end
      op(5'h0e, 8'h00, 8'h00, 8'h00);
      check(flagsOut[0], 1'b1);
      op(5'h02, 8'h0f, 8'h00, 8'h00);
      check({flagsOut[4], resultOut}, 9'h110);
      op(5'h0f, 8'h00, 8'h00, 8'h00);
      check(flagsOut[0], 1'b0);
      op(5'h03, 8'h05, 8'h06, 8'h00);
      check(flagsOut[2:0], 3'b101);
      op(5'h05, 8'hf0, 8'h0f, 8'h00);
      check(flagsOut[2:1], 2'b01);
      for (int i = 0; i < 8; i++)
      begin
         op(SOP[i], SA[i], SB[i], 8'h00);
         check({flagsOut[2:0], resultOut}, SX[i]);
      end
      op(5'h0d, 8'h04, 8'h02, 8'h00);
      check(flagsOut[0], 1'b1);
      op(5'h0d, 8'h04, 8'h03, 8'h00);
      check(flagsOut[0], 1'b0);
      op(5'h10, 8'h00, 8'h00, 8'h00);
      check({flagsOut[5], flagsOut[3]}, PRIO_LEVEL0);
      op(5'h11, 8'h00, 8'h00, 8'h00);
      check({flagsOut[5], flagsOut[3]}, PRIO_LEVEL3);
      op(5'h13, 8'h00, 8'h00, 8'h00);
      check({flagsOut[5], flagsOut[3], waitingOut}, 3'b101);
      op(5'h11, 8'h00, 8'h00, 8'h00);
      op(5'h12, 8'h00, 8'h00, 8'h00);
      check({flagsOut[5], flagsOut[3], haltedOut}, 3'b101);
      bus(1'b0, 32'h4, 32'h0, rd);
      check(rd, 32'h0000_067f);
      rd = {24'h0, flagsOut};
      op(5'h17, 8'h00, 8'h00, 8'h01);
      check({pushValid, pushData}, {1'b1, rd[7:0]});
      check({flagsOut[5], flagsOut[3], haltedOut, waitingOut}, 4'b0100);
      op(5'h16, 8'h00, 8'h00, rd[7:0]);
      check(flagsOut, rd[7:0]);
      op(5'h14, 8'h00, 8'h00, 8'h00);
      check({pushValid, pushData}, {1'b1, rd[7:0]});
      op(5'h15, 8'h00, 8'h00, 8'h3a);
      check(flagsOut, 8'hfa);
      for (int s = 0; s < 8; s++)
      begin
         op(5'h18, {6'h00, s[2:1]}, {7'h00, s[0]}, 8'h00);
         check({branchValid, branchTaken},
               {1'b1, POP_FLAGS[POS[s / 2]] == s[0]});
      end
      tally_and_finish();
   end

endmodule : testbench
`default_nettype wire
